// ==== bench/charger_host_watchdog_startup_bench.sv ====
// self-checking bench for the charger watchdog, battery path and start-up
`timescale 1ns/1ps
module charger_host_watchdog_startup_bench;
	import chw_pkg::*;
	localparam int TK = int'(SLOW_DIV); // one slow tick, in cycles
	localparam logic [13:0] ICYC = 14'h0008;
	logic sys_clk, resetn, vin_ok, margin, batt_ok, batt_dpl, ocp, boost_c;
	logic adapt_done, adapt_ok, src_done, int_req, host_write, wr_reg_reset, wr_wd_restart;
	logic wr_wd_sel, wr_force_off, force_off_data, sda, scl, force_off, restart_bit, flag;
	logic host_mode, dflt, int_n, i2c_ready, regs_dflt, reg_en, adapt_req, src_req, buck_en;
	logic bsw, boost_en, ship, sys_en, latch;
	logic [1:0] wd_sel_data, wd_sel;
	logic [13:0] notes[$];
	logic [13:0] width;
	logic [7:0] rnd;
	int fails, n_checks, n;
	// ==========================================================
	// design and host
	chw_top #(.INT_CYC(ICYC), .REG_TICKS(24'h000004), .RETRY_TICKS(24'h000003),
		.WD1_TICKS(24'h000005), .WD2_TICKS(24'h000006), .WD3_TICKS(24'h000007)) dut_u (
		.sys_clk(sys_clk), .resetn(resetn), .vin_uvlo_ok(vin_ok),
		.input_over_battery_margin(margin), .batt_uvlo_ok(batt_ok),
		.battery_over_discharge_level(batt_dpl), .batt_ocp(ocp), .sda_in(sda), .scl_in(scl),
		.boost_cond(boost_c), .host_write(host_write), .wr_reg_reset(wr_reg_reset),
		.wr_wd_restart(wr_wd_restart), .wr_wd_sel(wr_wd_sel), .wd_sel_data(wd_sel_data),
		.wr_force_off(wr_force_off), .force_off_data(force_off_data), .adapt_done(adapt_done),
		.adapt_ok(adapt_ok), .src_done(src_done), .int_req(int_req), .wd_sel(wd_sel),
		.battery_switch_force_off(force_off), .watchdog_restart_bit(restart_bit),
		.watchdog_expired_flag(flag), .host_mode(host_mode), .default_charge(dflt),
		.int_n(int_n), .i2c_ready(i2c_ready), .regs_default(regs_dflt),
		.internal_regulator(reg_en), .adapt_req(adapt_req), .src_req(src_req),
		.buck_en(buck_en), .battery_switch(bsw), .boost_en(boost_en), .shipping_mode(ship),
		.sys_supply_en(sys_en), .battery_switch_overcurrent_latch(latch));
	chw_host_model host_u (.sys_clk(sys_clk), .host_write(host_write),
		.wr_reg_reset(wr_reg_reset), .wr_wd_restart(wr_wd_restart), .wr_wd_sel(wr_wd_sel),
		.wd_sel_data(wd_sel_data), .wr_force_off(wr_force_off),
		.force_off_data(force_off_data), .sda_in(sda), .scl_in(scl));
	// ==========================================================
	// clock, shared tasks
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check_bit(input string nm, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic check_sel(input string nm, input logic [1:0] e, input logic [1:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic check_width(input logic [13:0] e, input logic [13:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("Error int_n low width expected %0d seen %0d", e, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// monitor: each interrupt pulse takes the oldest note off the queue
	always @(posedge sys_clk) begin
		if (resetn !== 1'b1) width <= 14'h0000;
		else if (int_n === 1'b0) width <= width + 14'h0001;
		else if (width != 14'h0000) begin
			if (notes.size() == 0) check_width(14'h0000, width);
			else check_width(notes.pop_front(), width);
			width <= 14'h0000;
		end
	end
	// watchdog against a hang, well above the expected run of about 24k cycles
	initial begin
		#(80000 * 25);
		fails++;
		conclude();
	end
	// ==========================================================
	// main sequence
	initial begin
		{vin_ok, margin, batt_ok, batt_dpl, ocp, boost_c} = 6'h00;
		{adapt_done, adapt_ok, src_done, int_req} = 4'h0;
		fails = 0;
		n_checks = 0;
		rnd = 8'h55;
		resetn = 1'b0;
		repeat (2) tick();
		resetn = 1'b1;
		check_sel("wd_sel", WD_SEL_RST, wd_sel);
		check_bit("host_mode", 1'b0, host_mode);
		check_bit("default_charge", 1'b1, dflt);
		// writes with no supply in range are ignored
		host_u.write(3'h0, 2'h2);
		check_sel("wd_sel", WD_SEL_RST, wd_sel);
		check_bit("host_mode", 1'b0, host_mode);
		batt_ok = 1'b1;
		batt_dpl = 1'b1;
		boost_c = 1'b1;
		for (n = 0; n < 20 && i2c_ready !== 1'b1; n++) tick();
		check_bit("regs_default", 1'b1, regs_dflt);
		repeat (3) tick();
		check_bit("i2c_ready", 1'b1, i2c_ready);
		check_bit("battery_switch", 1'b1, bsw);
		check_bit("boost_en", 1'b1, boost_en);
		check_bit("flag", 1'b0, flag);
		// host mode kept alive by restarts spaced under the timeout
		host_u.write(3'h0, 2'h1);
		check_bit("host_mode", 1'b1, host_mode);
		check_bit("default_charge", 1'b0, dflt);
		repeat (4) begin
			repeat (3 * TK) tick();
			check_bit("host_mode", 1'b1, host_mode);
			host_u.write(3'h1, 2'h0);
			check_bit("restart_bit", 1'b1, restart_bit);
			tick();
			check_bit("restart_bit", 1'b0, restart_bit);
		end
		// no restart: expiry falls back to default mode and interrupts
		notes.push_back(ICYC);
		for (n = 0; n < 8 * TK && host_mode !== 1'b0; n++) tick();
		check_bit("expiry late enough", 1'b1, n >= 4 * TK);
		tick();
		check_bit("flag", 1'b1, flag);
		check_bit("default_charge", 1'b1, dflt);
		// timeout field 00 never expires
		host_u.write(3'h0, WD_SEL_OFF);
		check_bit("host_mode", 1'b1, host_mode);
		check_bit("flag", 1'b0, flag);
		repeat (10 * TK) tick();
		check_bit("host_mode", 1'b1, host_mode);
		// register reset brings back defaults after a random timeout field and force-off set
		rnd = lfsr_next(rnd);
		host_u.write(3'h0, rnd[1:0]);
		check_sel("wd_sel", rnd[1:0], wd_sel);
		host_u.write(3'h3, 2'h1);
		check_bit("force_off", 1'b1, force_off);
		host_u.write(3'h2, 2'h0);
		check_sel("wd_sel", WD_SEL_RST, wd_sel);
		check_bit("force_off", FORCE_OFF_RST, force_off);
		check_bit("regs_default", 1'b1, regs_dflt);
		// middle timeout select: after a restart, expiry lands on the sixth tick
		host_u.write(3'h0, 2'h2);
		host_u.write(3'h1, 2'h0);
		notes.push_back(ICYC);
		for (n = 0; n < 8 * TK && host_mode !== 1'b0; n++) tick();
		check_bit("expiry sel 2 window", 1'b1, n >= 5 * TK && n < 6 * TK);
		check_bit("flag", 1'b1, flag);
		host_u.write(3'h0, WD_SEL_OFF);
		// forced off, then shipping with both bus lines low
		host_u.write(3'h3, 2'h1);
		repeat (2) tick();
		check_bit("battery_switch", 1'b0, bsw);
		check_bit("boost_en", 1'b0, boost_en);
		host_u.bus_low = 1'b1;
		repeat (6) tick();
		check_bit("shipping_mode", 1'b1, ship);
		check_bit("sys_supply_en", 1'b0, sys_en);
		host_u.bus_low = 1'b0;
		host_u.write(3'h3, 2'h0);
		repeat (6) tick();
		check_bit("shipping_mode", 1'b0, ship);
		check_bit("battery_switch", 1'b1, bsw);
		// random spaced external interrupt events, one pulse each
		repeat (3) begin
			rnd = lfsr_next(rnd);
			notes.push_back(ICYC);
			int_req = 1'b1;
			tick();
			int_req = 1'b0;
			repeat (int'(ICYC) + 6 + int'(rnd[3:0])) tick();
		end
		// overcurrent latch holds the switch off
		ocp = 1'b1;
		repeat (6) tick();
		ocp = 1'b0;
		repeat (6) tick();
		check_bit("latch", 1'b1, latch);
		check_bit("battery_switch", 1'b0, bsw);
		// input start-up: a margin drop restarts the qualifying count
		vin_ok = 1'b1;
		margin = 1'b1;
		repeat (2 * TK) tick();
		margin = 1'b0;
		repeat (8) tick();
		margin = 1'b1;
		for (n = 0; n < 6 * TK && reg_en !== 1'b1; n++) tick();
		check_bit("qualify not early", 1'b1, n >= 3 * TK);
		check_bit("internal_regulator", 1'b1, reg_en);
		check_bit("adapt_req", 1'b1, adapt_req);
		check_bit("src_req", 1'b0, src_req);
		check_bit("latch", 1'b1, latch);
		// failed adapter check, retried after the retry count
		adapt_done = 1'b1;
		tick();
		adapt_done = 1'b0;
		adapt_ok = 1'b1;
		tick();
		check_bit("adapt_req", 1'b0, adapt_req);
		for (n = 0; n < 5 * TK && adapt_req !== 1'b1; n++) tick();
		check_bit("retry not early", 1'b1, n >= 2 * TK);
		check_bit("adapt_req", 1'b1, adapt_req);
		notes.push_back(ICYC);
		adapt_done = 1'b1;
		tick();
		adapt_done = 1'b0;
		adapt_ok = 1'b0;
		tick();
		check_bit("src_req", 1'b1, src_req);
		check_bit("buck_en", 1'b0, buck_en);
		repeat (20) tick();
		notes.push_back(ICYC);
		src_done = 1'b1;
		tick();
		src_done = 1'b0;
		tick();
		check_bit("buck_en", 1'b1, buck_en);
		check_bit("src_req", 1'b0, src_req);
		repeat (20) tick();
		// input removal clears start-up and releases the latch
		vin_ok = 1'b0;
		margin = 1'b0;
		repeat (8) tick();
		check_bit("latch", 1'b0, latch);
		check_bit("buck_en", 1'b0, buck_en);
		check_bit("internal_regulator", 1'b0, reg_en);
		check_bit("battery_switch", 1'b1, bsw);
		repeat (20) tick();
		check_bit("interrupt notes left", 1'b1, notes.size() == 0);
		conclude();
	end
endmodule // charger_host_watchdog_startup_bench

// ==== bench/chw_host_model.sv ====
// host processor model: issues register write strobes and holds the bus lines
`timescale 1ns/1ps
module chw_host_model (
	input wire logic sys_clk, // system clock
	output logic host_write, // any register write, pulse
	output logic wr_reg_reset, // register-reset write
	output logic wr_wd_restart, // watchdog restart write
	output logic wr_wd_sel, // timeout field write
	output logic [1:0] wd_sel_data, // timeout field value
	output logic wr_force_off, // force-off bit write
	output logic force_off_data, // force-off bit value
	output logic sda_in, // data line level
	output logic scl_in // clock line level
);
	// ==========================================================
	// bus lines: pulled up unless the host holds them low
	logic bus_low;
	assign sda_in = !bus_low;
	assign scl_in = !bus_low;
	initial begin
		bus_low = 1'b0;
		{host_write, wr_reg_reset, wr_wd_restart, wr_wd_sel, wr_force_off} = 5'h00;
		wd_sel_data = 2'h0;
		force_off_data = 1'b0;
	end
	// ==========================================================
	// one write: strobes held over one sampling edge, then released
	// op 0 timeout field, 1 restart, 2 register reset, 3 force-off, 4 other
	task automatic write(input logic [2:0] op, input logic [1:0] val);
		@(posedge sys_clk);
		#1;
		host_write = 1'b1;
		wr_wd_sel = (op == 3'h0);
		wr_wd_restart = (op == 3'h1); // restart keeps host mode alive
		wr_reg_reset = (op == 3'h2);
		wr_force_off = (op == 3'h3);
		wd_sel_data = val;
		force_off_data = val[0];
		@(posedge sys_clk);
		#1;
		{host_write, wr_reg_reset, wr_wd_restart, wr_wd_sel, wr_force_off} = 5'h00;
		// released data no longer shows the written value
		wd_sel_data = ~val;
		force_off_data = ~val[0];
	endtask
endmodule // chw_host_model

// ==== src/chw_pkg.sv ====
// constants and types shared by the charger host watchdog and start-up logic
//
// Overview of operation
// - interrupt is one low pulse, 256 us
// - logic powered from either supply in range; defaults on entry
// - register-reset write restores all register defaults
// - two-bit field selects timeout; zero disables
// - expired flag zero in host, one after expiry
// - power-on starts default mode, watchdog stopped
// - any write in default mode enters host mode
// - watchdog timeout returns device to default mode
// - restart bit clears itself after restarting count
// - default mode charges on default settings alone
// - battery only, above discharge level: switch on
// - on battery alone, boost when conditions hold
// - force-off bit opens switch, no charge/discharge
// - no input, forced off, bus low: shipping
// - overcurrent latches switch off until input removed
// - input start: regulator, adapter check, source detect
// - regulator starts after 220 ms qualified input
// - failed adapter check repeats every 2 seconds
package chw_pkg;
	// ==========================================================
	// clock rates and timing
	localparam int SYS_CLK_HZ = 40000000;
	localparam int SLOW_CLK_HZ = 70000;
	localparam logic [9:0] SLOW_DIV = 10'(SYS_CLK_HZ / SLOW_CLK_HZ);
	localparam int INT_PULSE_US = 256;
	localparam logic [13:0] INT_PULSE_CYC = 14'(INT_PULSE_US * (SYS_CLK_HZ / 1000000));
	localparam int REG_QUAL_MS = 220;
	localparam logic [23:0] REG_QUAL_TICKS = 24'(REG_QUAL_MS * SLOW_CLK_HZ / 1000);
	localparam int ADAPT_RETRY_S = 2;
	localparam logic [23:0] ADAPT_RETRY_TICKS = 24'(ADAPT_RETRY_S * SLOW_CLK_HZ);
	localparam int WD_T1_S = 40;
	localparam int WD_T2_S = 80;
	localparam int WD_T3_S = 160;
	localparam logic [23:0] WD_T1_TICKS = 24'(WD_T1_S * SLOW_CLK_HZ);
	localparam logic [23:0] WD_T2_TICKS = 24'(WD_T2_S * SLOW_CLK_HZ);
	localparam logic [23:0] WD_T3_TICKS = 24'(WD_T3_S * SLOW_CLK_HZ);
	// ==========================================================
	// register fields and reset values
	localparam logic [1:0] WD_SEL_OFF = 2'h0;
	localparam logic [1:0] WD_SEL_RST = 2'h1;
	localparam logic FORCE_OFF_RST = 1'h0;
	// ==========================================================
	// synchronised pin inputs: bit positions
	localparam int PIN_W = 8;
	localparam int PIN_VIN_OK = 0;
	localparam int PIN_VIN_MARGIN = 1;
	localparam int PIN_BATT_OK = 2;
	localparam int PIN_BATT_DPL = 3;
	localparam int PIN_BATT_OCP = 4;
	localparam int PIN_SDA = 5;
	localparam int PIN_SCL = 6;
	localparam int PIN_BOOST = 7;
	// ==========================================================
	// start-up sequence states
	typedef enum logic [5:0] {
		CHW_IDLE = 6'h01,
		CHW_QUAL = 6'h02,
		CHW_ADAPT = 6'h04,
		CHW_RETRY = 6'h08,
		CHW_SRC = 6'h10,
		CHW_RUN = 6'h20
	} chw_start_t;
endpackage

// ==== src/chw_sync3.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module chw_sync3 #(
	parameter int W = 8
) (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic [W-1:0] pin, // raw asynchronous pins
	output logic [W-1:0] clean // filtered level
);
	// ==========================================================
	// per-bit chain; first stage feeds only the second
	genvar g;
	for (g = 0; g < W; g++) begin : g_bit
		logic s1;
		logic s2;
		logic s3;
		logic val;
		// a change counts once stages two and three agree
		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				val <= 1'b0;
			end else begin
				s1 <= pin[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					val <= s3;
				end
			end
		end
		assign clean[g] = val;
	end
endmodule // chw_sync3

// ==== src/chw_top.sv ====
// watchdog, battery path and input start-up control of the charger
`timescale 1ns/1ps
module chw_top #(
	parameter logic [13:0] INT_CYC = chw_pkg::INT_PULSE_CYC, // interrupt width, cycles
	parameter logic [23:0] REG_TICKS = chw_pkg::REG_QUAL_TICKS, // qualify, slow ticks
	parameter logic [23:0] RETRY_TICKS = chw_pkg::ADAPT_RETRY_TICKS, // retry, slow ticks
	parameter logic [23:0] WD1_TICKS = chw_pkg::WD_T1_TICKS, // timeout sel 1
	parameter logic [23:0] WD2_TICKS = chw_pkg::WD_T2_TICKS, // timeout sel 2
	parameter logic [23:0] WD3_TICKS = chw_pkg::WD_T3_TICKS // timeout sel 3
) (
	input wire logic sys_clk, // 40 MHz system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic vin_uvlo_ok, // pin: input in communication range
	input wire logic input_over_battery_margin, // pin: input above battery + margin
	input wire logic batt_uvlo_ok, // pin: battery in communication range
	input wire logic battery_over_discharge_level, // pin: battery above discharge level
	input wire logic batt_ocp, // pin: discharge over switch limit
	input wire logic sda_in, // pin: data line level
	input wire logic scl_in, // pin: clock line level
	input wire logic boost_cond, // pin: other boost conditions met
	input wire logic host_write, // any register write, pulse
	input wire logic wr_reg_reset, // one written to register-reset bit
	input wire logic wr_wd_restart, // one written to watchdog_restart_bit
	input wire logic wr_wd_sel, // timeout field written
	input wire logic [1:0] wd_sel_data, // timeout field value
	input wire logic wr_force_off, // force-off bit written
	input wire logic force_off_data, // force-off bit value
	input wire logic adapt_done, // adapter check finished, pulse
	input wire logic adapt_ok, // adapter check result
	input wire logic src_done, // source detection finished, pulse
	input wire logic int_req, // external interrupt event, pulse
	output logic [1:0] wd_sel, // timeout field
	output logic battery_switch_force_off, // force-off bit
	output logic watchdog_restart_bit, // restart bit, self-clearing
	output logic watchdog_expired_flag, // watchdog expired flag
	output logic host_mode, // host mode active
	output logic default_charge, // charging on default settings
	output logic int_n, // interrupt, active low pulse
	output logic i2c_ready, // logic powered, bus accepted
	output logic regs_default, // pulse: load register defaults
	output logic internal_regulator, // regulator enable
	output logic adapt_req, // request adapter check
	output logic src_req, // request source detection
	output logic buck_en, // start step-down converter
	output logic battery_switch, // battery switch on
	output logic boost_en, // boost mode
	output logic shipping_mode, // shipping mode
	output logic sys_supply_en, // system supplied
	output logic battery_switch_overcurrent_latch // latched off
);
	import chw_pkg::*;

	// ==========================================================
	// all state of the block
	typedef struct packed {
		logic [1:0] wd_sel;
		logic force_off;
		logic restart_bit;
		logic host_mode;
		logic wd_flag;
		logic dflt_chg;
		logic [23:0] wd_cnt;
		logic [9:0] pre_cnt;
		logic tick;
		logic [13:0] int_cnt;
		logic int_n;
		logic int_pend;
		logic pwr_ok;
		logic regs_dflt;
		chw_start_t start;
		logic [23:0] tmr;
		logic reg_en;
		logic adapt_req;
		logic src_req;
		logic buck_en;
		logic vin_d;
		logic ocp_latch;
		logic bsw;
		logic boost;
		logic ship;
		logic sys_en;
	} chw_state_t;

	chw_state_t st;
	chw_state_t next_st;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin;

	// ==========================================================
	// pin synchronisers
	assign pin_raw = {boost_cond, scl_in, sda_in, batt_ocp, battery_over_discharge_level,
		batt_uvlo_ok, input_over_battery_margin, vin_uvlo_ok};

	chw_sync3 #(
		.W(PIN_W)
	) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin(pin_raw),
		.clean(pin)
	);

	// ==========================================================
	// next-state logic
	logic [23:0] wd_lim;
	logic vin_ok;
	logic vin_qual;
	logic any_wr;
	logic wd_run;
	logic wd_exp;
	logic ev;

	// timeout length from the select field
	always_comb begin
		case (st.wd_sel)
			2'h1: wd_lim = WD1_TICKS;
			2'h2: wd_lim = WD2_TICKS;
			2'h3: wd_lim = WD3_TICKS;
			default: wd_lim = 24'h000000;
		endcase
	end

	always_comb begin
		next_st = st;
		vin_ok = pin[PIN_VIN_OK];
		vin_qual = pin[PIN_VIN_OK] & pin[PIN_VIN_MARGIN];
		any_wr = host_write | wr_reg_reset | wr_wd_restart | wr_wd_sel | wr_force_off;
		// zero select stops the count altogether
		wd_run = st.host_mode & (st.wd_sel != WD_SEL_OFF);
		wd_exp = wd_run & st.tick & (st.wd_cnt >= wd_lim - 24'h000001);
		ev = int_req;

		// slow timebase standing in for the internal oscillator
		next_st.tick = (st.pre_cnt == SLOW_DIV - 10'h001);
		next_st.pre_cnt = next_st.tick ? 10'h000 : st.pre_cnt + 10'h001;

		// logic alive on whichever supply is in range
		next_st.pwr_ok = vin_ok | pin[PIN_BATT_OK];
		next_st.regs_dflt = wr_reg_reset | (next_st.pwr_ok & ~st.pwr_ok);

		// register writes
		next_st.restart_bit = 1'b0;
		if (wr_wd_sel) begin
			next_st.wd_sel = wd_sel_data;
		end
		if (wr_force_off) begin
			next_st.force_off = force_off_data;
		end
		if (wr_wd_restart) begin
			next_st.restart_bit = 1'b1;
			next_st.wd_cnt = 24'h000000;
		end
		if (wr_reg_reset) begin
			next_st.wd_sel = WD_SEL_RST;
			next_st.force_off = FORCE_OFF_RST;
			next_st.restart_bit = 1'b0;
		end

		// watchdog count and mode changes
		if (!st.host_mode) begin
			if (any_wr) begin
				next_st.host_mode = 1'b1;
				next_st.wd_flag = 1'b0;
				next_st.wd_cnt = 24'h000000;
			end
		end else if (!wd_run) begin
			next_st.wd_cnt = 24'h000000;
		end else if (wd_exp && !wr_wd_restart) begin
			next_st.host_mode = 1'b0;
			next_st.wd_flag = 1'b1;
			next_st.wd_cnt = 24'h000000;
			ev = 1'b1;
		end else if (st.tick && !wr_wd_restart) begin
			next_st.wd_cnt = st.wd_cnt + 24'h000001;
		end
		next_st.dflt_chg = ~next_st.host_mode;

		// start-up from input power
		case (st.start)
			CHW_IDLE: begin
				next_st.tmr = 24'h000000;
				if (vin_qual) begin
					next_st.start = CHW_QUAL;
				end
			end
			CHW_QUAL: begin
				// any dip restarts the qualifying time
				if (!vin_qual) begin
					next_st.start = CHW_IDLE;
					next_st.tmr = 24'h000000;
				end else if (st.tick) begin
					if (st.tmr == REG_TICKS - 24'h000001) begin
						next_st.reg_en = 1'b1;
						next_st.adapt_req = 1'b1;
						next_st.start = CHW_ADAPT;
						next_st.tmr = 24'h000000;
					end else begin
						next_st.tmr = st.tmr + 24'h000001;
					end
				end
			end
			CHW_ADAPT: begin
				if (adapt_done) begin
					next_st.adapt_req = 1'b0;
					next_st.tmr = 24'h000000;
					if (adapt_ok) begin
						next_st.src_req = 1'b1;
						next_st.start = CHW_SRC;
						ev = 1'b1;
					end else begin
						next_st.start = CHW_RETRY;
					end
				end
			end
			CHW_RETRY: begin
				if (st.tick) begin
					if (st.tmr == RETRY_TICKS - 24'h000001) begin
						next_st.adapt_req = 1'b1;
						next_st.start = CHW_ADAPT;
						next_st.tmr = 24'h000000;
					end else begin
						next_st.tmr = st.tmr + 24'h000001;
					end
				end
			end
			CHW_SRC: begin
				if (src_done) begin
					next_st.src_req = 1'b0;
					next_st.buck_en = 1'b1;
					next_st.start = CHW_RUN;
					ev = 1'b1;
				end
			end
			CHW_RUN: begin
				next_st.start = CHW_RUN;
			end
			default: begin
				next_st.start = CHW_IDLE;
			end
		endcase
		// losing input power drops the whole sequence
		if (!vin_ok) begin
			next_st.start = CHW_IDLE;
			next_st.tmr = 24'h000000;
			next_st.reg_en = 1'b0;
			next_st.adapt_req = 1'b0;
			next_st.src_req = 1'b0;
			next_st.buck_en = 1'b0;
		end

		// battery path; latch set wins over the disconnect clear
		next_st.vin_d = vin_ok;
		if (st.bsw && pin[PIN_BATT_OCP]) begin
			next_st.ocp_latch = 1'b1;
		end else if (st.vin_d && !vin_ok) begin
			next_st.ocp_latch = 1'b0;
		end
		next_st.ship = ~vin_ok & st.force_off & ~pin[PIN_SDA] & ~pin[PIN_SCL];
		next_st.bsw = ~st.force_off & ~next_st.ocp_latch
			& (vin_ok | pin[PIN_BATT_DPL]);
		next_st.boost = ~vin_ok & next_st.bsw & pin[PIN_BOOST];
		next_st.sys_en = ~next_st.ship & (vin_ok | next_st.bsw);

		// interrupt pulse; events during a pulse queue one more
		next_st.int_pend = st.int_pend | ev;
		if (!st.int_n) begin
			if (st.int_cnt == INT_CYC - 14'h0001) begin
				next_st.int_n = 1'b1;
				next_st.int_cnt = 14'h0000;
			end else begin
				next_st.int_cnt = st.int_cnt + 14'h0001;
			end
		end else if (st.int_pend) begin
			next_st.int_n = 1'b0;
			next_st.int_pend = ev;
		end

		// out of communication range the register fields, watchdog and mode hold defaults
		if (!next_st.pwr_ok) begin
			next_st.wd_sel = WD_SEL_RST;
			next_st.force_off = FORCE_OFF_RST;
			next_st.restart_bit = 1'b0;
			next_st.host_mode = 1'b0;
			next_st.wd_flag = 1'b0;
			next_st.dflt_chg = 1'b1;
			next_st.wd_cnt = 24'h000000;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st <= '0;
			st.wd_sel <= WD_SEL_RST;
			st.force_off <= FORCE_OFF_RST;
			st.dflt_chg <= 1'b1;
			st.int_n <= 1'b1;
			st.start <= CHW_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs, each a field of the state register
	assign wd_sel = st.wd_sel;
	assign battery_switch_force_off = st.force_off;
	assign watchdog_restart_bit = st.restart_bit;
	assign watchdog_expired_flag = st.wd_flag;
	assign host_mode = st.host_mode;
	assign default_charge = st.dflt_chg;
	assign int_n = st.int_n;
	assign i2c_ready = st.pwr_ok;
	assign regs_default = st.regs_dflt;
	assign internal_regulator = st.reg_en;
	assign adapt_req = st.adapt_req;
	assign src_req = st.src_req;
	assign buck_en = st.buck_en;
	assign battery_switch = st.bsw;
	assign boost_en = st.boost;
	assign shipping_mode = st.ship;
	assign sys_supply_en = st.sys_en;
	assign battery_switch_overcurrent_latch = st.ocp_latch;

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	int_width_a: assert property ($rose(st.int_n) |-> $past(st.int_cnt) == INT_CYC - 14'h0001)
		else $error("interrupt pulse width wrong");
	int_low_a: assert property (!st.int_n |-> st.int_cnt < INT_CYC)
		else $error("interrupt held low too long");
	wd_flag_a: assert property (st.host_mode |-> !st.wd_flag)
		else $error("expired flag set in host mode");
	start_default_a: assert property ($past(!resetn) |-> !st.host_mode && !st.wd_flag)
		else $error("not in default mode after reset");
	write_host_a: assert property (host_write && !st.host_mode && st.pwr_ok && pin[PIN_VIN_OK]
		|=> st.host_mode)
		else $error("write did not enter host mode");
	wd_expire_a: assert property (wd_exp && !wr_wd_restart && next_st.pwr_ok
		|=> !st.host_mode && st.wd_flag && st.int_pend ##1 (!st.int_n || st.int_pend))
		else $error("expiry did not return to default mode");
	wd_off_a: assert property (st.host_mode && st.wd_sel == WD_SEL_OFF && next_st.pwr_ok
		|=> st.host_mode)
		else $error("disabled watchdog expired");
	restart_clr_a: assert property (wr_wd_restart && !wr_reg_reset && next_st.pwr_ok
		|=> st.restart_bit && st.wd_cnt == 24'h000000 ##1 !st.restart_bit)
		else $error("restart bit did not clear");
	reg_reset_a: assert property (wr_reg_reset && next_st.pwr_ok
		|=> st.wd_sel == WD_SEL_RST && !st.force_off && st.regs_dflt)
		else $error("register reset did not load defaults");
	force_off_a: assert property (st.force_off |=> !st.bsw && !st.boost)
		else $error("switch on while forced off");
	ship_a: assert property (st.ship |-> !st.sys_en)
		else $error("system supplied in shipping mode");
	ocp_hold_a: assert property (st.ocp_latch && pin[PIN_VIN_OK] == st.vin_d
		|=> st.ocp_latch)
		else $error("overcurrent latch released early");
	reg_qual_a: assert property ($rose(st.reg_en) |-> $past(st.tmr) == REG_TICKS - 24'h000001)
		else $error("regulator started before qualify time");

	host_cov_c: cover property (!st.host_mode ##1 st.host_mode);
	expire_cov_c: cover property (st.host_mode ##1 st.wd_flag);
	retry_cov_c: cover property (st.start == CHW_RETRY ##1 st.start == CHW_ADAPT);
	ship_cov_c: cover property ($rose(st.ship));
endmodule // chw_top
